// ---- rdsk_alu.sv ----
// Purpose: Combinational result, flag and skip logic for one instruction
// Assumes: Operands are stable during the execute cycle
// Notes:   Subtraction is done as an add of the inverted operand
`timescale 1ns/1ps
`default_nettype none
module rdsk_alu
   import rdsk_pkg::*;
(
   // Operands
   input  wire rdsk_op_e     op_i,
   input  wire logic [7:0]   mem_i,
   input  wire logic [7:0]   wreg_i,
   input  wire logic [7:0]   imm_i,
   input  wire logic [2:0]   bit_i,
   input  wire logic [3:0]   flags_i,
   // Results
   output logic      [7:0]   res_o,
   output logic              to_mem_o,
   output logic              to_wreg_o,
   output logic      [3:0]   flags_o,
   output logic              skip_o,
   output logic              bad_o
);
   logic [7:0] sub_b;
   logic       sub_cin;
   logic [8:0] sum;
   logic [4:0] half;

   always_comb begin
      sub_b   = (op_i == OP_SUBI) ? imm_i : mem_i;
      sub_cin = (op_i == OP_SBC || op_i == OP_MINUS_BORROW_TO_MEMORY) ? flags_i[F_C] : 1'b1;
      sum     = {1'b0, wreg_i} + {1'b0, ~sub_b} + {8'h00, sub_cin};
      half    = {1'b0, wreg_i[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
   end

   always_comb begin
      res_o     = mem_i;
      to_mem_o  = 1'b0;
      to_wreg_o = 1'b0;
      flags_o   = flags_i;
      skip_o    = 1'b0;
      bad_o     = 1'b0;
      case (op_i)
         OP_RLA:  begin res_o = {mem_i[6:0], mem_i[7]}; to_wreg_o = 1'b1; end
         OP_RLC:  begin res_o = {mem_i[6:0], flags_i[F_C]}; to_mem_o = 1'b1; flags_o[F_C] = mem_i[7]; end
         OP_ROTATE_LEFT_CARRY_TO_WORKING: begin res_o = {mem_i[6:0], flags_i[F_C]}; to_wreg_o = 1'b1; flags_o[F_C] = mem_i[7]; end
         OP_RR:   begin res_o = {mem_i[0], mem_i[7:1]}; to_mem_o = 1'b1; end
         OP_RRA:  begin res_o = {mem_i[0], mem_i[7:1]}; to_wreg_o = 1'b1; end
         OP_RRC:  begin res_o = {flags_i[F_C], mem_i[7:1]}; to_mem_o = 1'b1; flags_o[F_C] = mem_i[0]; end
         OP_ROTATE_RIGHT_CARRY_TO_WORKING: begin res_o = {flags_i[F_C], mem_i[7:1]}; to_wreg_o = 1'b1; flags_o[F_C] = mem_i[0]; end
         OP_SBC, OP_SUB, OP_SUBI, OP_MINUS_BORROW_TO_MEMORY, OP_MINUS_TO_MEMORY: begin
            res_o         = sum[7:0];
            to_wreg_o     = (op_i == OP_SBC || op_i == OP_SUB || op_i == OP_SUBI);
            to_mem_o      = (op_i == OP_MINUS_BORROW_TO_MEMORY || op_i == OP_MINUS_TO_MEMORY);
            flags_o[F_C]  = sum[8];
            flags_o[F_AC] = half[4];
            flags_o[F_Z]  = (sum[7:0] == ZERO_BYTE);
            flags_o[F_OV] = (wreg_i[7] == ~sub_b[7]) && (sum[7] != wreg_i[7]);
         end
         OP_SDZ:  begin res_o = mem_i - ONE_BYTE; to_mem_o = 1'b1; skip_o = (res_o == ZERO_BYTE); end
         OP_DECREMENT_TO_WORKING_SKIP_NIL: begin res_o = mem_i - ONE_BYTE; to_wreg_o = 1'b1; skip_o = (res_o == ZERO_BYTE); end
         OP_SIZ:  begin res_o = mem_i + ONE_BYTE; to_mem_o = 1'b1; skip_o = (res_o == ZERO_BYTE); end
         OP_INCREMENT_TO_WORKING_SKIP_NIL: begin res_o = mem_i + ONE_BYTE; to_wreg_o = 1'b1; skip_o = (res_o == ZERO_BYTE); end
         OP_SNZ:  begin skip_o = mem_i[bit_i]; end
         OP_SETB: begin res_o = ALL_ONES; to_mem_o = 1'b1; end
         OP_SETI: begin res_o = mem_i | (ONE_BYTE << bit_i); to_mem_o = 1'b1; end
         OP_SWAP: begin res_o = {mem_i[3:0], mem_i[7:4]}; to_mem_o = 1'b1; end
         default: begin bad_o = 1'b1; end
      endcase
   end
endmodule : rdsk_alu
`default_nettype wire

// ---- rdsk_dmem.sv ----
// Purpose: Byte-wide data memory with registered read data
// Assumes: Array contents are not reset
// Notes:   Read returns the old byte when written in the same cycle
`timescale 1ns/1ps
`default_nettype none
module rdsk_dmem
   import rdsk_pkg::*;
#(
   parameter int DEPTH = MEM_DEPTH
) (
   // Clock and reset
   input  wire logic  ref_clk_i,
   input  wire logic  sys_rst_i,
   // Memory port
   rdsk_mem_if.mem    mport
);
   logic [DW-1:0] store [DEPTH];
   logic [DW-1:0] rdata_ff;

   always_ff @(posedge ref_clk_i) begin
      if (mport.we) begin
         store[mport.addr] <= mport.wdata;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         rdata_ff <= ZERO_BYTE;
      end else begin
         rdata_ff <= store[mport.addr];
      end
   end

   assign mport.rdata = rdata_ff;
endmodule : rdsk_dmem
`default_nettype wire

// ---- rdsk_mem_if.sv ----
// Purpose: Port bundle between the datapath top and its data memory
// Assumes: Single port, synchronous read
// Notes:   Read data appear one clock after the address
`timescale 1ns/1ps
`default_nettype none
interface rdsk_mem_if;
   import rdsk_pkg::*;
   logic [AW-1:0] addr;
   logic          we;
   logic [DW-1:0] wdata;
   logic [DW-1:0] rdata;
   modport ctl (output addr, output we, output wdata, input rdata);
   modport mem (input addr, input we, input wdata, output rdata);
endinterface : rdsk_mem_if
`default_nettype wire

// ---- rdsk_pkg.sv ----
// Purpose: Shared constants and types of the rotate/subtract/skip datapath
// Assumes: 32-bit APB register bus, 8-bit data path, 64-byte data memory
// Notes:   Register offsets are byte addresses; memory window is one byte per word
`default_nettype none
package rdsk_pkg;
   localparam int          DW            = 8;
   localparam int          AW            = 6;
   localparam int          MEM_DEPTH     = 64;
   localparam int          PAW           = 12;
   // Register map
   localparam logic [11:0] OFF_CTRL      = 12'h000;
   localparam logic [11:0] OFF_IMM       = 12'h004;
   localparam logic [11:0] OFF_WREG      = 12'h008;
   localparam logic [11:0] OFF_STATUS    = 12'h00c;
   localparam logic [3:0]  MEM_WIN_PAGE  = 4'h1;
   // Control word layout
   localparam int          CTRL_OP_LSB   = 0;
   localparam int          CTRL_BIT_LSB  = 8;
   localparam int          CTRL_ADDR_LSB = 16;
   localparam int          CTRL_GO_BIT   = 31;
   // Flag vector and status layout
   localparam int          F_C           = 0;
   localparam int          F_AC          = 1;
   localparam int          F_Z           = 2;
   localparam int          F_OV          = 3;
   localparam int          ST_SKIP_BIT   = 4;
   localparam int          ST_BAD_BIT    = 5;
   localparam int          ST_BUSY_BIT   = 8;
   localparam int          ST_CYC_LSB    = 12;
   localparam logic [1:0]  CYC_ONE       = 2'h1;
   localparam logic [1:0]  CYC_TWO       = 2'h2;
   localparam logic [7:0]  ALL_ONES      = 8'hff;
   localparam logic [7:0]  ONE_BYTE      = 8'h01;
   localparam logic [7:0]  ZERO_BYTE     = 8'h00;
   localparam logic [3:0]  FLAGS_RST     = 4'h0;

   typedef enum logic [4:0] {
      OP_NONE     = 5'b00000, OP_RLA  = 5'b00001, OP_RLC  = 5'b00010, OP_ROTATE_LEFT_CARRY_TO_WORKING = 5'b00011,
      OP_RR       = 5'b00100, OP_RRA  = 5'b00101, OP_RRC  = 5'b00110, OP_ROTATE_RIGHT_CARRY_TO_WORKING = 5'b00111,
      OP_SBC      = 5'b01000, OP_MINUS_BORROW_TO_MEMORY = 5'b01001, OP_SUB  = 5'b01010, OP_MINUS_TO_MEMORY = 5'b01011,
      OP_SUBI     = 5'b01100, OP_SDZ  = 5'b01101, OP_DECREMENT_TO_WORKING_SKIP_NIL = 5'b01110, OP_SIZ  = 5'b01111,
      OP_INCREMENT_TO_WORKING_SKIP_NIL     = 5'b10000, OP_SNZ  = 5'b10001, OP_SETB = 5'b10010, OP_SETI = 5'b10011,
      OP_SWAP     = 5'b10100
   } rdsk_op_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_FETCH = 2'b01,
      ST_EXEC  = 2'b10,
      ST_DUMMY = 2'b11
   } rdsk_state_e;
endpackage : rdsk_pkg
`default_nettype wire

// ---- rdsk_top.sv ----
// Purpose: APB-controlled execution datapath for rotate, subtract, skip,
//          set and swap instructions on a byte-wide data memory
// Assumes: One APB master; ref_clk_i at 100 MHz; synchronous reset
// Notes:   A launched instruction reads memory, executes in one cycle and
//          spends one dummy cycle when it skips
`timescale 1ns/1ps
`default_nettype none
module rdsk_top
   import rdsk_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             sys_rst_i,
   // APB slave
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [PAW-1:0]   paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic      [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o,
   // Core status
   output logic                  skip_o,
   output logic                  busy_o
);
   rdsk_mem_if mif ();

   rdsk_state_e state_ff;
   rdsk_state_e nxt_state;
   rdsk_op_e    op_ff;
   logic [2:0]  bit_ff;
   logic [AW-1:0] addr_ff;
   logic [7:0]  imm_ff;
   logic [7:0]  wreg_ff;
   logic [3:0]  flags_ff;
   logic        skip_seen_ff;
   logic        bad_op_ff;
   logic [1:0]  cyc_ff;
   logic        dummy_ff;
   logic        busy_ff;
   logic        stage_ff;
   logic        pready_ff;
   logic        pslverr_ff;
   logic [31:0] prdata_ff;

   // Address decode
   logic        sel_ctrl;
   logic        sel_imm;
   logic        sel_wreg;
   logic        sel_status;
   logic        sel_mem;
   logic        mapped;
   logic        refuse;
   logic        done;
   logic        wr_ok;
   logic        launch;
   logic [31:0] rd_mux;

   // ALU results
   logic [7:0]  alu_res;
   logic        alu_to_mem;
   logic        alu_to_wreg;
   logic [3:0]  alu_flags;
   logic        alu_skip;
   logic        alu_bad;
   logic        in_exec;

   always_comb begin
      sel_ctrl   = (paddr_i == OFF_CTRL);
      sel_imm    = (paddr_i == OFF_IMM);
      sel_wreg   = (paddr_i == OFF_WREG);
      sel_status = (paddr_i == OFF_STATUS);
      sel_mem    = (paddr_i[11:8] == MEM_WIN_PAGE) && (paddr_i[1:0] == 2'h0);
      mapped     = sel_ctrl | sel_imm | sel_wreg | sel_status | sel_mem;
      // Register reads and status writes are safe while busy; memory accesses and other writes are not
      refuse     = !mapped || (busy_ff && (sel_mem || (pwrite_i && !sel_status)) );
      done       = psel_i && penable_i && pready_ff;
      wr_ok      = done && pwrite_i && !pslverr_ff;
      launch     = wr_ok && sel_ctrl && pwdata_i[CTRL_GO_BIT];
      in_exec    = (state_ff == ST_EXEC);
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (sel_ctrl) begin
         rd_mux[CTRL_OP_LSB +: 5]    = op_ff;
         rd_mux[CTRL_BIT_LSB +: 3]   = bit_ff;
         rd_mux[CTRL_ADDR_LSB +: AW] = addr_ff;
      end else if (sel_imm) begin
         rd_mux[7:0] = imm_ff;
      end else if (sel_wreg) begin
         rd_mux[7:0] = wreg_ff;
      end else if (sel_status) begin
         rd_mux[3:0]             = flags_ff;
         rd_mux[ST_SKIP_BIT]     = skip_seen_ff;
         rd_mux[ST_BAD_BIT]      = bad_op_ff;
         rd_mux[ST_BUSY_BIT]     = busy_ff;
         rd_mux[ST_CYC_LSB +: 2] = cyc_ff;
      end else if (sel_mem) begin
         rd_mux[7:0] = mif.rdata;
      end
   end

   // APB handshake: one cycle to address memory, one to present the answer
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         stage_ff   <= 1'b0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else if (done) begin
         stage_ff   <= 1'b0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else if (psel_i && penable_i && !stage_ff) begin
         stage_ff <= 1'b1;
      end else if (psel_i && penable_i && stage_ff) begin
         pready_ff  <= 1'b1;
         pslverr_ff <= refuse;
         prdata_ff  <= (refuse || pwrite_i) ? 32'h0000_0000 : rd_mux;
      end
   end

   // Memory port: the executor owns it in the fetch and execute states, not in the dummy cycle
   always_comb begin
      if (state_ff == ST_FETCH || state_ff == ST_EXEC) begin
         mif.addr  = addr_ff;
         mif.we    = in_exec && alu_to_mem;
         mif.wdata = alu_res;
      end else begin
         mif.addr  = paddr_i[2 +: AW];
         mif.we    = wr_ok && sel_mem;
         mif.wdata = pwdata_i[7:0];
      end
   end

   rdsk_dmem #(
      .DEPTH (MEM_DEPTH)
   ) u_dmem (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .mport     (mif.mem)
   );

   rdsk_alu u_alu (
      .op_i      (op_ff),
      .mem_i     (mif.rdata),
      .wreg_i    (wreg_ff),
      .imm_i     (imm_ff),
      .bit_i     (bit_ff),
      .flags_i   (flags_ff),
      .res_o     (alu_res),
      .to_mem_o  (alu_to_mem),
      .to_wreg_o (alu_to_wreg),
      .flags_o   (alu_flags),
      .skip_o    (alu_skip),
      .bad_o     (alu_bad)
   );

   // Sequencer
   always_comb begin
      case (state_ff)
         ST_IDLE:  nxt_state = launch ? ST_FETCH : ST_IDLE;
         ST_FETCH: nxt_state = ST_EXEC;
         ST_EXEC:  nxt_state = alu_skip ? ST_DUMMY : ST_IDLE;
         ST_DUMMY: nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_ff <= ST_IDLE;
         busy_ff  <= 1'b0;
         dummy_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         busy_ff  <= (nxt_state != ST_IDLE);
         dummy_ff <= (nxt_state == ST_DUMMY);
      end
   end

   // Instruction word and immediate
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         op_ff   <= OP_NONE;
         bit_ff  <= 3'h0;
         addr_ff <= '0;
      end else if (wr_ok && sel_ctrl) begin
         op_ff   <= rdsk_op_e'(pwdata_i[CTRL_OP_LSB +: 5]);
         bit_ff  <= pwdata_i[CTRL_BIT_LSB +: 3];
         addr_ff <= pwdata_i[CTRL_ADDR_LSB +: AW];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         imm_ff <= ZERO_BYTE;
      end else if (wr_ok && sel_imm) begin
         imm_ff <= pwdata_i[7:0];
      end
   end

   // Working register: only results that target it land here
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         wreg_ff <= ZERO_BYTE;
      end else if (in_exec && alu_to_wreg) begin
         wreg_ff <= alu_res;
      end else if (wr_ok && sel_wreg) begin
         wreg_ff <= pwdata_i[7:0];
      end
   end

   // Arithmetic flags; ops that leave them alone return them unchanged
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         flags_ff <= FLAGS_RST;
      end else if (in_exec) begin
         flags_ff <= alu_flags;
      end else if (wr_ok && sel_status) begin
         flags_ff <= pwdata_i[3:0];
      end
   end

   // Sticky status; hardware set wins over a write-one clear
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         skip_seen_ff <= 1'b0;
         bad_op_ff    <= 1'b0;
      end else begin
         if (in_exec && alu_skip) begin
            skip_seen_ff <= 1'b1;
         end else if (wr_ok && sel_status && pwdata_i[ST_SKIP_BIT]) begin
            skip_seen_ff <= 1'b0;
         end
         if (in_exec && alu_bad) begin
            bad_op_ff <= 1'b1;
         end else if (wr_ok && sel_status && pwdata_i[ST_BAD_BIT]) begin
            bad_op_ff <= 1'b0;
         end
      end
   end

   // Cycle count of the last instruction
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         cyc_ff <= 2'h0;
      end else if (in_exec) begin
         cyc_ff <= alu_skip ? CYC_TWO : CYC_ONE;
      end
   end

   assign prdata_o  = prdata_ff;
   assign pready_o  = pready_ff;
   assign pslverr_o = pslverr_ff;
   assign skip_o    = dummy_ff;
   assign busy_o    = busy_ff;

   // Checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_exec(rdsk_op_e o);
      in_exec && op_ff == o;
   endsequence

   sequence s_skip_tail;
      (state_ff == ST_DUMMY && skip_o) ##1 (state_ff == ST_IDLE && !skip_o);
   endsequence

   a_rotl_working: assert property (s_exec(OP_RLA) |-> !mif.we ##1
      (wreg_ff == {$past(mif.rdata[6:0]), $past(mif.rdata[7])}) && flags_ff == $past(flags_ff))
      else $error("rotate left to working wrong");
   a_rlc_memory: assert property (s_exec(OP_RLC) |-> mif.we &&
      mif.wdata == {mif.rdata[6:0], flags_ff[F_C]} ##1 flags_ff[F_C] == $past(mif.rdata[7]))
      else $error("rotate left through carry wrong");
   a_rotate_left_carry_to_working_working: assert property (s_exec(OP_ROTATE_LEFT_CARRY_TO_WORKING) |-> !mif.we ##1
      wreg_ff == {$past(mif.rdata[6:0]), $past(flags_ff[F_C])} && flags_ff[F_C] == $past(mif.rdata[7]))
      else $error("carry rotate left to working wrong");
   a_rr_memory: assert property (s_exec(OP_RR) |->
      mif.we && mif.wdata == {mif.rdata[0], mif.rdata[7:1]} ##1 $stable(flags_ff))
      else $error("rotate right wrong");
   a_rra_working: assert property (s_exec(OP_RRA) |-> !mif.we ##1
      wreg_ff == {$past(mif.rdata[0]), $past(mif.rdata[7:1])} && $stable(flags_ff))
      else $error("rotate right to working wrong");
   a_rrc_memory: assert property (s_exec(OP_RRC) |-> mif.we &&
      mif.wdata == {flags_ff[F_C], mif.rdata[7:1]} ##1 flags_ff[F_C] == $past(mif.rdata[0]))
      else $error("rotate right through carry wrong");
   a_rotate_right_carry_to_working_working: assert property (s_exec(OP_ROTATE_RIGHT_CARRY_TO_WORKING) |-> !mif.we ##1
      wreg_ff == {$past(flags_ff[F_C]), $past(mif.rdata[7:1])} && flags_ff[F_C] == $past(mif.rdata[0]))
      else $error("carry rotate right to working wrong");
   a_sbc_result: assert property (s_exec(OP_SBC) |=>
      wreg_ff == 8'($past(wreg_ff) - $past(mif.rdata) - 8'(!$past(flags_ff[F_C]))))
      else $error("subtract with borrow wrong");
   a_minus_to_memory_memory: assert property (s_exec(OP_MINUS_TO_MEMORY) |->
      mif.we && mif.wdata == 8'(wreg_ff - mif.rdata) ##1 flags_ff[F_Z] == ($past(mif.wdata) == ZERO_BYTE))
      else $error("subtract to memory wrong");
   a_subi_flags: assert property (s_exec(OP_SUBI) |=>
      wreg_ff == 8'($past(wreg_ff) - $past(imm_ff)) && flags_ff[F_C] == ($past(wreg_ff) >= $past(imm_ff)))
      else $error("subtract immediate wrong");
   a_sdz_skip: assert property (s_exec(OP_SDZ) |-> mif.we &&
      mif.wdata == 8'(mif.rdata - ONE_BYTE) && alu_skip == (mif.rdata == ONE_BYTE))
      else $error("decrement skip wrong");
   a_decrement_to_working_skip_nil_skip: assert property (s_exec(OP_DECREMENT_TO_WORKING_SKIP_NIL) |-> !mif.we &&
      alu_skip == (mif.rdata == ONE_BYTE) ##1 wreg_ff == 8'($past(mif.rdata) - ONE_BYTE))
      else $error("decrement to working wrong");
   a_skip_dummy: assert property (in_exec && alu_skip |=> s_skip_tail)
      else $error("skip did not spend one dummy cycle");
   a_noskip_one: assert property (in_exec && !alu_skip |=> state_ff == ST_IDLE && cyc_ff == CYC_ONE)
      else $error("non-skip took more than one cycle");
   a_set_byte: assert property ((s_exec(OP_SETB) or s_exec(OP_SETI)) |-> mif.we &&
      mif.wdata[bit_ff] && (op_ff == OP_SETI || mif.wdata == ALL_ONES) ##1 $stable(flags_ff))
      else $error("set byte or bit wrong");
   a_siz_skip: assert property ((s_exec(OP_SIZ) or s_exec(OP_INCREMENT_TO_WORKING_SKIP_NIL)) |->
      alu_skip == (mif.rdata == ALL_ONES) && mif.we == (op_ff == OP_SIZ) ##1 $stable(flags_ff))
      else $error("increment skip wrong");
   a_snz_quiet: assert property (s_exec(OP_SNZ) |-> !mif.we &&
      alu_skip == mif.rdata[bit_ff] ##1 $stable(wreg_ff) && $stable(flags_ff))
      else $error("bit test skip wrong");
   a_swap_nibble: assert property (s_exec(OP_SWAP) |->
      mif.we && mif.wdata == {mif.rdata[3:0], mif.rdata[7:4]} ##1 $stable(flags_ff))
      else $error("nibble swap wrong");
endmodule : rdsk_top
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the rotate/subtract/skip datapath
// Assumes: Operands staged over APB, then one instruction launched
// Notes:   Busy and skip cycles are counted beside the bus tasks
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rdsk_pkg::*;
   logic        ref_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, skip_o, busy_o, err;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, rd;
   int          fail_count = 0, checks_done = 0, n_busy = 0, n_skip = 0;

   rdsk_top rdsk_top_inst (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .skip_o(skip_o), .busy_o(busy_o));

   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      n_busy <= n_busy + int'(busy_o === 1'b1);
      n_skip <= n_skip + int'(skip_o === 1'b1);
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Request held until pready is sampled; one idle cycle keeps drivers single per step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel_i   <= 1'b1;
      pwrite_i <= wr;
      paddr_i  <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         fail_count++;
         tally_and_finish();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask : apb

   // Memory byte 63 is the operand; the immediate gets the same byte
   task automatic run_op(input logic [4:0] op, input logic [2:0] bt, input logic [7:0] m, w,
                         input logic [3:0] fl, input logic [7:0] em, ew, input logic [3:0] efl, input logic sk);
      int b0, s0, n;
      apb(1'b1, 12'h1fc, {24'h0, m});
      apb(1'b1, OFF_WREG, {24'h0, w});
      apb(1'b1, OFF_IMM, {24'h0, m});
      apb(1'b1, OFF_STATUS, {26'h0, 2'h3, fl});
      b0 = n_busy;
      s0 = n_skip;
      apb(1'b1, OFF_CTRL, {1'b1, 9'h0, 6'h3f, 5'h0, bt, 3'h0, op});
      n = 0;
      while (busy_o !== 1'b0 && n < 20) begin
         @(posedge ref_clk_i);
         n++;
      end
      if (busy_o !== 1'b0) begin
         fail_count++;
         tally_and_finish();
      end
      apb(1'b0, 12'h1fc, 32'h0);
      chk(rd, {24'h0, em});
      apb(1'b0, OFF_WREG, 32'h0);
      chk(rd, {24'h0, ew});
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd, {18'h0, sk ? CYC_TWO : CYC_ONE, 7'h0, sk, efl});
      chk(32'(n_busy - b0), sk ? 32'h3 : 32'h2);
      chk(32'(n_skip - s0), {31'h0, sk});
   endtask : run_op

   task automatic t_rotate();
      run_op(5'h01, 3'h0, 8'h96, 8'h3c, 4'h1, 8'h96, 8'h2d, 4'h1, 1'b0);
      run_op(5'h02, 3'h0, 8'h96, 8'h3c, 4'h0, 8'h2c, 8'h3c, 4'h1, 1'b0);
      run_op(5'h03, 3'h0, 8'h96, 8'h3c, 4'h0, 8'h96, 8'h2c, 4'h1, 1'b0);
      run_op(5'h04, 3'h0, 8'h97, 8'h3c, 4'h1, 8'hcb, 8'h3c, 4'h1, 1'b0);
      run_op(5'h05, 3'h0, 8'h97, 8'h3c, 4'ha, 8'h97, 8'hcb, 4'ha, 1'b0);
      run_op(5'h06, 3'h0, 8'h97, 8'h3c, 4'h0, 8'h4b, 8'h3c, 4'h1, 1'b0);
      run_op(5'h07, 3'h0, 8'h96, 8'h3c, 4'h1, 8'h96, 8'hcb, 4'h0, 1'b0);
      $display("rotate test done");
   endtask : t_rotate

   task automatic t_subtract();
      run_op(5'h0a, 3'h0, 8'h30, 8'h50, 4'h0, 8'h30, 8'h20, 4'h3, 1'b0);
      run_op(5'h0b, 3'h0, 8'h01, 8'h80, 4'h0, 8'h7f, 8'h80, 4'h9, 1'b0);
      run_op(5'h08, 3'h0, 8'h0f, 8'h10, 4'h0, 8'h0f, 8'h00, 4'h5, 1'b0);
      run_op(5'h09, 3'h0, 8'h07, 8'h05, 4'h1, 8'hfe, 8'h05, 4'h0, 1'b0);
      run_op(5'h0c, 3'h0, 8'hff, 8'h7f, 4'h0, 8'hff, 8'h80, 4'ha, 1'b0);
      $display("subtract test done");
   endtask : t_subtract

   task automatic t_skip();
      run_op(5'h0d, 3'h0, 8'h01, 8'h3c, 4'hf, 8'h00, 8'h3c, 4'hf, 1'b1);
      run_op(5'h0d, 3'h0, 8'h00, 8'h3c, 4'hf, 8'hff, 8'h3c, 4'hf, 1'b0);
      run_op(5'h0e, 3'h0, 8'h01, 8'h3c, 4'hf, 8'h01, 8'h00, 4'hf, 1'b1);
      run_op(5'h0f, 3'h0, 8'hff, 8'h3c, 4'hf, 8'h00, 8'h3c, 4'hf, 1'b1);
      run_op(5'h10, 3'h0, 8'hfe, 8'h3c, 4'hf, 8'hfe, 8'hff, 4'hf, 1'b0);
      run_op(5'h11, 3'h7, 8'h80, 8'h3c, 4'hf, 8'h80, 8'h3c, 4'hf, 1'b1);
      run_op(5'h11, 3'h0, 8'hfe, 8'h3c, 4'hf, 8'hfe, 8'h3c, 4'hf, 1'b0);
      $display("skip test done");
   endtask : t_skip

   task automatic t_misc();
      run_op(5'h12, 3'h0, 8'h12, 8'h3c, 4'h5, 8'hff, 8'h3c, 4'h5, 1'b0);
      run_op(5'h13, 3'h5, 8'h00, 8'h3c, 4'h5, 8'h20, 8'h3c, 4'h5, 1'b0);
      run_op(5'h14, 3'h0, 8'h3c, 8'h3c, 4'h5, 8'hc3, 8'h3c, 4'h5, 1'b0);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Undefined op code: sticky bad bit, one cycle, flags kept
      apb(1'b1, OFF_CTRL, 32'h8000_0000);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk(rd, 32'h0000_1025);
      $display("set swap bus test done");
   endtask : t_misc

   initial begin
      sys_rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 12'h0;
      pwdata_i = 32'h0;
      repeat (16) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge ref_clk_i);
      t_rotate();
      t_subtract();
      t_skip();
      t_misc();
      tally_and_finish();
   end
endmodule : tb_top
`default_nettype wire
